// file: rtl/sweep_trigger_sequencer.sv
// sweep trigger sequencer: trigger sources, delay, hold-off, auto trigger, run control
`timescale 1ns/1ps
`include "sweep_trigger_consts.svh"
module sweep_trigger_sequencer #(
	parameter logic [31:0] PERIOD_MAX_CYC = `PERIOD_MAX_CYC,
	parameter logic [31:0] OFFSET_MAX_CYC = `OFFSET_MAX_CYC,
	parameter logic [31:0] DELAY_MAX_CYC = `DELAY_MAX_CYC,
	parameter logic [31:0] HOLDOFF_MAX_CYC = `HOLDOFF_MAX_CYC,
	parameter logic [31:0] AUTO_MIN_US = `AUTO_MIN_US,
	parameter logic [31:0] AUTO_MAX_US = `AUTO_MAX_US,
	parameter logic [7:0] US_CYC = `US_CYC
) (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	input wire logic ext_trig_in,
	input wire logic signed [15:0] td_amp_in,
	input wire logic signed [15:0] if_level_in,
	input wire logic signed [15:0] td_reach_in,
	input wire logic sweep_done_in,
	output logic sweep_start_out,
	output logic sweeping_out,
	output logic waiting_out,
	output logic clear_history_out,
	output logic hw_limited_out,
	output logic [1:0] meas_type_out,
	output logic [13:0] avg_index_out
);
	localparam logic [31:0] PER_MIN = 32'(`PERIOD_MIN_CYC);
	localparam logic signed [15:0] LVL_MIN = 16'(`LEVEL_MIN);
	localparam logic signed [15:0] LVL_MAX = 16'(`LEVEL_MAX);
	localparam logic [13:0] AVG_MAX = 14'(`AVG_MAX);

	sweep_trigger_pkg::state_e state_q;
	sweep_trigger_pkg::src_e src_q;
	logic slope_neg_q, cont_q, avg_trace_q, run_q;
	logic [1:0] meas_q;
	logic [31:0] period_q, delay_q, auto_q, holdoff_q;
	logic signed [31:0] offset_q;
	logic signed [15:0] level_q;
	logic [13:0] avg_q, avg_cnt_q, remain_q;
	logic [3:0] cmd_q;
	logic [31:0] grid_q, target_q, dly_cnt_q, hold_cnt_q, auto_cnt_q;
	logic [7:0] us_cnt_q;
	logic ext_s1_q, ext_s2_q, ext_prev_q;
	logic signed [15:0] td_amp_q, if_lvl_q;
	logic td_above_q, if_above_q, td_prev_q, if_prev_q;
	logic per_fire_q, clear_q, start_q;
	logic signed [15:0] td_thr;
	logic [31:0] off_mag, off_rem, wd_u;
	logic signed [31:0] wd_s;
	logic gated, free_src, edge_src, edge_hit, trig_ok, auto_hit, active;
	logic w_ctrl, w_cmd;

	assign wd_u = wdata_in;
	assign wd_s = wdata_in;
	assign w_ctrl = wr_in && addr_in == `REG_CTRL;
	assign w_cmd = wr_in && addr_in == `REG_CMD;

	// register writes; numeric settings are clamped into their legal ranges, control fields are stored as written
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			src_q <= sweep_trigger_pkg::SRC_FREE;
			slope_neg_q <= 1'b0;
			meas_q <= 2'b00;
			avg_trace_q <= 1'b0;
			period_q <= `RST_PERIOD;
			offset_q <= 32'sh0000_0000;
			level_q <= 16'sh0000;
			delay_q <= 32'h0000_0000;
			auto_q <= 32'h0000_0000;
			holdoff_q <= 32'h0000_0000;
			avg_q <= `RST_AVG;
		end else if (wr_in) begin
			case (addr_in)
				`REG_CTRL: begin
					src_q <= sweep_trigger_pkg::src_e'(wdata_in[`CTRL_SRC_LSB +: 3]);
					slope_neg_q <= wdata_in[`CTRL_SLOPE_NEG];
					meas_q <= wdata_in[`CTRL_MEAS_LSB +: 2];
					avg_trace_q <= wdata_in[`CTRL_AVG_TRACE];
				end
				`REG_CMD: begin
					if (wdata_in[`CMD_RESET_OFFSET])
						offset_q <= 32'sh0000_0000;
				end
				`REG_PERIOD: begin
					if (wd_u < PER_MIN)
						period_q <= PER_MIN;
					else if (wd_u > PERIOD_MAX_CYC)
						period_q <= PERIOD_MAX_CYC;
					else
						period_q <= wd_u;
				end
				`REG_OFFSET: begin
					if (wd_s > $signed(OFFSET_MAX_CYC))
						offset_q <= $signed(OFFSET_MAX_CYC);
					else if (wd_s < -$signed(OFFSET_MAX_CYC))
						offset_q <= -$signed(OFFSET_MAX_CYC);
					else
						offset_q <= wd_s;
				end
				`REG_LEVEL: begin
					if ($signed(wdata_in[15:0]) < LVL_MIN)
						level_q <= LVL_MIN;
					else if ($signed(wdata_in[15:0]) > LVL_MAX)
						level_q <= LVL_MAX;
					else
						level_q <= $signed(wdata_in[15:0]);
				end
				`REG_DELAY: begin
					if (wd_u > DELAY_MAX_CYC)
						delay_q <= DELAY_MAX_CYC;
					else
						delay_q <= wd_u;
				end
				`REG_AUTO: begin
					if (wd_u == 32'h0000_0000)
						auto_q <= 32'h0000_0000;
					else if (wd_u < AUTO_MIN_US)
						auto_q <= AUTO_MIN_US;
					else if (wd_u > AUTO_MAX_US)
						auto_q <= AUTO_MAX_US;
					else
						auto_q <= wd_u;
				end
				`REG_HOLDOFF: begin
					if (wd_u > HOLDOFF_MAX_CYC)
						holdoff_q <= HOLDOFF_MAX_CYC;
					else
						holdoff_q <= wd_u;
				end
				`REG_AVG: begin
					if (wdata_in[31:0] < 32'(`AVG_MIN))
						avg_q <= 14'(`AVG_MIN);
					else if (wdata_in[31:0] > 32'(`AVG_MAX))
						avg_q <= AVG_MAX;
					else
						avg_q <= wdata_in[13:0];
				end
				default: ;
			endcase
		end
	end

	// commands are registered so run/hold, single and restart act one cycle after their write; offset reset acts on the write itself
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			cmd_q <= 4'h0;
		else
			cmd_q <= w_cmd ? wdata_in[3:0] : 4'h0;
	end

	// input capture: external pin through two flops, level buses registered once
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_prev_q <= 1'b0;
			td_amp_q <= 16'sh0000;
			if_lvl_q <= 16'sh0000;
			td_above_q <= 1'b0;
			if_above_q <= 1'b0;
			td_prev_q <= 1'b0;
			if_prev_q <= 1'b0;
		end else begin
			ext_s1_q <= ext_trig_in;
			ext_s2_q <= ext_s1_q;
			ext_prev_q <= ext_s2_q;
			td_amp_q <= td_amp_in;
			if_lvl_q <= if_level_in;
			td_above_q <= td_amp_q >= td_thr;
			if_above_q <= if_lvl_q >= level_q;
			td_prev_q <= td_above_q;
			if_prev_q <= if_above_q;
		end
	end

	// the time-domain path cannot reach above the present gain setup, so clamp there
	assign td_thr = (level_q > td_reach_in) ? td_reach_in : level_q;
	assign hw_limited_out = level_q > td_reach_in;

	// one edge detector per qualified input: 0 external pin, 1 time-domain level, 2 IF-stage level
	logic [2:0] lvl_now, lvl_old, rise_hit, fall_hit, pol_hit;
	assign lvl_now = {if_above_q, td_above_q, ext_s2_q};
	assign lvl_old = {if_prev_q, td_prev_q, ext_prev_q};
	for (genvar i = 0; i < 3; i++) begin : g_edge
		assign rise_hit[i] = lvl_now[i] & ~lvl_old[i];
		assign fall_hit[i] = lvl_old[i] & ~lvl_now[i];
		assign pol_hit[i] = slope_neg_q ? fall_hit[i] : rise_hit[i];
	end

	// edge select per source; only one cycle per crossing passes
	always_comb begin
		edge_hit = 1'b0;
		case (src_q)
			sweep_trigger_pkg::SRC_EXT: edge_hit = pol_hit[0];
			sweep_trigger_pkg::SRC_TD_LEVEL: edge_hit = pol_hit[1];
			sweep_trigger_pkg::SRC_IF_LEVEL: edge_hit = pol_hit[2];
			default: edge_hit = 1'b0;
		endcase
	end

	// periodic grid and its shifted firing point
	assign off_mag = offset_q[31] ? 32'(-offset_q) : 32'(offset_q);
	assign off_rem = off_mag % period_q;
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			grid_q <= 32'h0000_0000;
			target_q <= 32'h0000_0000;
			per_fire_q <= 1'b0;
		end else begin
			grid_q <= (grid_q >= period_q - 32'h0000_0001) ? 32'h0000_0000 : grid_q + 32'h0000_0001;
			target_q <= (offset_q[31] && off_rem != 32'h0000_0000) ? period_q - off_rem : off_rem;
			per_fire_q <= grid_q == target_q;
		end
	end

	assign gated = meas_q != sweep_trigger_pkg::MEAS_SPECTROGRAM;
	assign free_src = !gated || src_q == sweep_trigger_pkg::SRC_FREE;
	assign edge_src = src_q == sweep_trigger_pkg::SRC_EXT || src_q == sweep_trigger_pkg::SRC_TD_LEVEL ||
		src_q == sweep_trigger_pkg::SRC_IF_LEVEL;
	assign trig_ok = gated && ((src_q == sweep_trigger_pkg::SRC_PERIODIC && per_fire_q) ||
		(edge_src && edge_hit && hold_cnt_q == 32'h0000_0000));
	assign auto_hit = gated && auto_q != 32'h0000_0000 && auto_cnt_q >= auto_q;
	assign active = run_q || remain_q != 14'h0000;

	// hold-off starts on every edge trigger accepted while armed, and keeps running while a sweep is going
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			hold_cnt_q <= 32'h0000_0000;
		else if (edge_src && edge_hit && hold_cnt_q == 32'h0000_0000 && state_q == sweep_trigger_pkg::ST_ARM)
			hold_cnt_q <= holdoff_q;
		else if (hold_cnt_q != 32'h0000_0000)
			hold_cnt_q <= hold_cnt_q - 32'h0000_0001;
	end

	// auto-trigger timer counts microseconds while armed
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			us_cnt_q <= 8'h00;
			auto_cnt_q <= 32'h0000_0000;
		end else if (state_q != sweep_trigger_pkg::ST_ARM) begin
			us_cnt_q <= 8'h00;
			auto_cnt_q <= 32'h0000_0000;
		end else if (us_cnt_q == US_CYC - 8'h01) begin
			us_cnt_q <= 8'h00;
			auto_cnt_q <= auto_cnt_q + 32'h0000_0001;
		end else begin
			us_cnt_q <= us_cnt_q + 8'h01;
		end
	end

	// history clear pulse follows the registered restart command
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			clear_q <= 1'b0;
		else
			clear_q <= cmd_q[`CMD_RESTART];
	end

	// average counter: restart wins over a sweep finishing in the same cycle
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			avg_cnt_q <= `RST_AVG;
		else if (cmd_q[`CMD_RESTART])
			avg_cnt_q <= 14'h0001;
		else if (state_q == sweep_trigger_pkg::ST_SWEEP && sweep_done_in && avg_cnt_q < avg_q)
			avg_cnt_q <= avg_cnt_q + 14'h0001;
	end

	// run control: continuous flag, toggled run, pending sweep count
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cont_q <= 1'b1;
			run_q <= 1'b1;
			remain_q <= 14'h0000;
		end else begin
			if (w_ctrl) begin
				cont_q <= wdata_in[`CTRL_CONT];
				run_q <= wdata_in[`CTRL_CONT];
			end else if (cmd_q[`CMD_SINGLE]) begin
				cont_q <= 1'b0;
				run_q <= 1'b0;
			end else if (cmd_q[`CMD_RUN_HOLD] && cont_q) begin
				run_q <= ~run_q;
			end
			if (cmd_q[`CMD_SINGLE] || (cmd_q[`CMD_RUN_HOLD] && !cont_q && remain_q == 14'h0000))
				remain_q <= 14'h0001;
			else if (cmd_q[`CMD_RESTART] && !cont_q)
				remain_q <= avg_trace_q ? avg_q : 14'h0001;
			else if (state_q == sweep_trigger_pkg::ST_SWEEP && sweep_done_in && remain_q != 14'h0000)
				remain_q <= remain_q - 14'h0001;
		end
	end

	// sequencer: hold, armed, delaying, sweeping
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_q <= sweep_trigger_pkg::ST_HOLD;
			dly_cnt_q <= 32'h0000_0000;
			start_q <= 1'b0;
		end else begin
			start_q <= 1'b0;
			case (state_q)
				sweep_trigger_pkg::ST_HOLD: begin
					if (active)
						state_q <= sweep_trigger_pkg::ST_ARM;
				end
				sweep_trigger_pkg::ST_ARM: begin
					if (!active) begin
						state_q <= sweep_trigger_pkg::ST_HOLD;
					end else if (free_src || auto_hit) begin
						state_q <= sweep_trigger_pkg::ST_SWEEP;
						start_q <= 1'b1;
					end else if (trig_ok) begin
						state_q <= sweep_trigger_pkg::ST_DELAY;
						dly_cnt_q <= 32'h0000_0000;
					end
				end
				sweep_trigger_pkg::ST_DELAY: begin
					if (dly_cnt_q >= delay_q) begin
						state_q <= sweep_trigger_pkg::ST_SWEEP;
						start_q <= 1'b1;
					end else begin
						dly_cnt_q <= dly_cnt_q + 32'h0000_0001;
					end
				end
				sweep_trigger_pkg::ST_SWEEP: begin
					// a sweep in flight always completes, even if hold was requested
					if (sweep_done_in) begin
						if (run_q || remain_q > 14'h0001)
							state_q <= sweep_trigger_pkg::ST_ARM;
						else
							state_q <= sweep_trigger_pkg::ST_HOLD;
					end
				end
				default: state_q <= sweep_trigger_pkg::ST_HOLD;
			endcase
		end
	end

	// register reads answer one cycle after the strobe; unmapped addresses read zero
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rdata_out <= 32'h0000_0000;
		end else if (rd_in) begin
			case (addr_in)
				`REG_CTRL: rdata_out <= {24'h00_0000, avg_trace_q, meas_q, cont_q, slope_neg_q, src_q};
				`REG_PERIOD: rdata_out <= period_q;
				`REG_OFFSET: rdata_out <= offset_q;
				`REG_LEVEL: rdata_out <= {{16{level_q[15]}}, level_q};
				`REG_DELAY: rdata_out <= delay_q;
				`REG_AUTO: rdata_out <= auto_q;
				`REG_HOLDOFF: rdata_out <= holdoff_q;
				`REG_AVG: rdata_out <= {18'h0_0000, avg_q};
				`REG_STATUS: rdata_out <= {2'b00, avg_cnt_q, 8'h00, run_q, hw_limited_out,
					state_q == sweep_trigger_pkg::ST_SWEEP, state_q == sweep_trigger_pkg::ST_ARM,
					2'b00, state_q};
				`REG_EXCESS: rdata_out <= hw_limited_out ? 32'(level_q - td_reach_in) : 32'h0000_0000;
				default: rdata_out <= 32'h0000_0000;
			endcase
		end else begin
			rdata_out <= 32'h0000_0000;
		end
	end

	assign sweep_start_out = start_q;
	assign sweeping_out = state_q == sweep_trigger_pkg::ST_SWEEP;
	assign waiting_out = state_q == sweep_trigger_pkg::ST_ARM && !free_src;
	assign clear_history_out = clear_q;
	assign meas_type_out = meas_q;
	assign avg_index_out = avg_cnt_q;
endmodule // sweep_trigger_sequencer

// file: rtl/sweep_trigger_consts.svh
// constants of the sweep trigger sequencer: offsets, fields, limits and timing counts
`ifndef SWEEP_TRIGGER_CONSTS_SVH
`define SWEEP_TRIGGER_CONSTS_SVH

`define CLK_MHZ 125
`define PERIOD_MIN_NS 100
`define PERIOD_MIN_CYC ((`PERIOD_MIN_NS * `CLK_MHZ + 999) / 1000)
`define PERIOD_MAX_MS 400
`define PERIOD_MAX_CYC (`PERIOD_MAX_MS * `CLK_MHZ * 1000)
`define OFFSET_MAX_MS 100
`define OFFSET_MAX_CYC (`OFFSET_MAX_MS * `CLK_MHZ * 1000)
`define DELAY_MAX_S 10
`define DELAY_MAX_CYC (`DELAY_MAX_S * `CLK_MHZ * 1000000)
`define HOLDOFF_MAX_S 10
`define HOLDOFF_MAX_CYC (`HOLDOFF_MAX_S * `CLK_MHZ * 1000000)
`define AUTO_MIN_MS 1
`define AUTO_MIN_US (`AUTO_MIN_MS * 1000)
`define AUTO_MAX_S 100
`define AUTO_MAX_US (`AUTO_MAX_S * 1000000)
`define US_CYC `CLK_MHZ
`define LEVEL_SCALE 100
`define LEVEL_MIN_DBM (-210)
`define LEVEL_MAX_DBM 30
`define LEVEL_MIN (`LEVEL_MIN_DBM * `LEVEL_SCALE)
`define LEVEL_MAX (`LEVEL_MAX_DBM * `LEVEL_SCALE)
`define AVG_MIN 1
`define AVG_MAX 10000

`define REG_CTRL 8'h00
`define REG_CMD 8'h04
`define REG_PERIOD 8'h08
`define REG_OFFSET 8'h0C
`define REG_LEVEL 8'h10
`define REG_DELAY 8'h14
`define REG_AUTO 8'h18
`define REG_HOLDOFF 8'h1C
`define REG_AVG 8'h20
`define REG_STATUS 8'h24
`define REG_EXCESS 8'h28

`define CTRL_SRC_LSB 0
`define CTRL_SLOPE_NEG 3
`define CTRL_CONT 4
`define CTRL_MEAS_LSB 5
`define CTRL_AVG_TRACE 7
`define CMD_RUN_HOLD 0
`define CMD_SINGLE 1
`define CMD_RESTART 2
`define CMD_RESET_OFFSET 3

`define RST_PERIOD 32'h0000_3D09
`define RST_CTRL 8'h10
`define RST_AVG 14'h0001

`endif

// file: rtl/sweep_trigger_pkg.sv
// types of the sweep trigger sequencer
package sweep_trigger_pkg;
	typedef enum logic [2:0] {
		SRC_FREE = 3'b000,
		SRC_EXT = 3'b001,
		SRC_PERIODIC = 3'b010,
		SRC_TD_LEVEL = 3'b011,
		SRC_IF_LEVEL = 3'b100
	} src_e;
	typedef enum logic [1:0] {
		MEAS_DENSITY = 2'b00,
		MEAS_SPECTROGRAM = 2'b01,
		MEAS_REALTIME = 2'b10
	} meas_e;
	typedef enum logic [1:0] {
		ST_HOLD = 2'b00,
		ST_ARM = 2'b01,
		ST_DELAY = 2'b10,
		ST_SWEEP = 2'b11
	} state_e;
endpackage

// file: dv/sweep_trigger_props.sv
// port assertions and covers for the sweep trigger sequencer
`timescale 1ns/1ps
`include "sweep_trigger_consts.svh"
module sweep_trigger_props (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [31:0] rdata_out,
	input wire logic sweep_done_in,
	input wire logic sweep_start_out,
	input wire logic sweeping_out,
	input wire logic waiting_out,
	input wire logic clear_history_out,
	input wire logic hw_limited_out,
	input wire logic [1:0] meas_type_out,
	input wire logic [13:0] avg_index_out
);
	logic cmd_restart;
	assign cmd_restart = wr_in && addr_in == `REG_CMD && wdata_in[2];
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!arst_n_in);
	a_start_one_cycle: assert property (sweep_start_out |=> !sweep_start_out)
		else $error("start pulse too long");
	a_start_then_sweep: assert property (sweep_start_out |=> sweeping_out)
		else $error("no sweeping after start");
	a_done_ends_sweep: assert property (sweeping_out && sweep_done_in |=> !sweeping_out)
		else $error("sweeping after done");
	a_wait_not_sweep: assert property (!(waiting_out && sweeping_out))
		else $error("waiting while sweeping");
	a_spectro_ungated: assert property (meas_type_out == sweep_trigger_pkg::MEAS_SPECTROGRAM |-> !waiting_out)
		else $error("spectrogram waits for trigger");
	a_clear_has_cause: assert property (clear_history_out |-> $past(cmd_restart) || $past(cmd_restart, 2))
		else $error("history cleared without restart");
	a_clear_one_cycle: assert property (clear_history_out |=> !clear_history_out)
		else $error("clear pulse too long");
	a_avg_in_range: assert property (avg_index_out >= 14'h0001 && avg_index_out <= 14'h2710)
		else $error("average counter out of range");
	a_rdata_idle_zero: assert property (!$past(rd_in) |-> rdata_out == 32'h0000_0000)
		else $error("read data outside read cycle");
	a_excess_zero: assert property ($past(rd_in && addr_in == `REG_EXCESS && !hw_limited_out) |-> rdata_out == 32'h0000_0000)
		else $error("excess nonzero when not limited");
	a_status_flags: assert property ($past(rd_in && addr_in == `REG_STATUS) |->
		rdata_out[5] == $past(sweeping_out) && rdata_out[6] == $past(hw_limited_out))
		else $error("status flags disagree with ports");
	c_spectro_start: cover property (sweep_start_out && meas_type_out == sweep_trigger_pkg::MEAS_SPECTROGRAM);
	c_restart: cover property (clear_history_out);
	c_limited: cover property (hw_limited_out);
	c_trigger_taken: cover property ($fell(waiting_out));
endmodule // sweep_trigger_props

bind sweep_trigger_sequencer sweep_trigger_props props_u (.clk_in(clk_in), .arst_n_in(arst_n_in),
	.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
	.sweep_done_in(sweep_done_in), .sweep_start_out(sweep_start_out), .sweeping_out(sweeping_out),
	.waiting_out(waiting_out), .clear_history_out(clear_history_out), .hw_limited_out(hw_limited_out),
	.meas_type_out(meas_type_out), .avg_index_out(avg_index_out));

// file: dv/sweep_far_side.sv
// model of the trigger source, level detectors and acquisition beside the sequencer
`timescale 1ns/1ps
module sweep_far_side #(
	parameter int DONE_LAT = 8
) (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic sweep_start_in,
	input wire logic ext_lvl_in,
	input wire logic signed [15:0] amp_in,
	input wire logic signed [15:0] lvl_in,
	input wire logic signed [15:0] reach_in,
	output logic ext_trig_out,
	output logic sweep_done_out,
	output logic signed [15:0] td_amp_out,
	output logic signed [15:0] if_level_out,
	output logic signed [15:0] td_reach_out
);
	logic [7:0] cnt_q;
	// trigger pin driven from a flop so every edge is clean and glitch free
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ext_trig_out <= 1'b0;
		end else begin
			ext_trig_out <= ext_lvl_in;
		end
	end
	always_ff @(posedge clk_in) begin
		td_amp_out <= amp_in;
		if_level_out <= lvl_in;
		td_reach_out <= reach_in;
	end
	// acquisition ends a fixed time after each start
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cnt_q <= 8'h00;
		end else if (sweep_start_in) begin
			cnt_q <= 8'(DONE_LAT);
		end else if (cnt_q != 8'h00) begin
			cnt_q <= cnt_q - 8'h01;
		end
	end
	assign sweep_done_out = (cnt_q == 8'h01);
endmodule // sweep_far_side

// file: dv/sweep_trigger_sequencer_test.sv
// self-checking bench for the sweep trigger sequencer
`timescale 1ns/1ps
`include "sweep_trigger_consts.svh"
module sweep_trigger_sequencer_test;
	logic clk_in, arst_n_in, wr_in, rd_in, ext_lvl, ext_trig, sweep_done;
	logic sweep_start_out, sweeping_out, waiting_out, clear_history_out, hw_limited_out;
	logic [7:0] addr_in;
	logic [31:0] wdata_in, rdata_out, rd_q;
	logic signed [15:0] amp, lvl, reach, td_amp, if_level, td_reach;
	logic [1:0] meas_type_out;
	logic [13:0] avg_index_out;
	int errors, cmp_count, starts, clears, n, s0, c0;
	sweep_trigger_sequencer #(.OFFSET_MAX_CYC(32'h0000_03E8),
		.HOLDOFF_MAX_CYC(32'h0000_03E8), .AUTO_MIN_US(32'h0000_0002),
		.AUTO_MAX_US(32'h0000_0032), .US_CYC(8'h04)) dut_u (.clk_in(clk_in), .arst_n_in(arst_n_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.ext_trig_in(ext_trig), .td_amp_in(td_amp), .if_level_in(if_level), .td_reach_in(td_reach),
		.sweep_done_in(sweep_done), .sweep_start_out(sweep_start_out), .sweeping_out(sweeping_out),
		.waiting_out(waiting_out), .clear_history_out(clear_history_out), .hw_limited_out(hw_limited_out),
		.meas_type_out(meas_type_out), .avg_index_out(avg_index_out));
	sweep_far_side far_u (.clk_in(clk_in), .arst_n_in(arst_n_in), .sweep_start_in(sweep_start_out),
		.ext_lvl_in(ext_lvl), .amp_in(amp), .lvl_in(lvl), .reach_in(reach), .ext_trig_out(ext_trig),
		.sweep_done_out(sweep_done), .td_amp_out(td_amp), .if_level_out(if_level), .td_reach_out(td_reach));
	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		if (sweep_start_out === 1'b1) starts <= starts + 1;
		if (clear_history_out === 1'b1) clears <= clears + 1;
	end
	task automatic test_done();
		$display("compares %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_word({31'h0000_0000, got}, {31'h0000_0000, exp});
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1;
		rd_q = rdata_out;
	endtask
	task automatic idle(input int k);
		repeat (k) @(posedge clk_in);
	endtask
	// counts cycles up to lim until a start pulse is seen
	task automatic wait_start(input int lim);
		n = 0;
		while (sweep_start_out !== 1'b1 && n < lim) begin
			@(posedge clk_in);
			#1;
			n++;
		end
	endtask
	task automatic ext_to(input logic v);
		@(posedge clk_in);
		ext_lvl <= v;
	endtask
	initial begin
		#200_000;
		errors++;
		$display("watchdog expired");
		test_done();
	end
	initial begin
		arst_n_in = 1'b0;
		{wr_in, rd_in, ext_lvl} = 3'b000;
		addr_in = 8'h00;
		wdata_in = 32'h0000_0000;
		amp = 16'hF830;
		lvl = 16'hF830;
		reach = 16'h7FFF;
		{errors, cmp_count, starts, clears} = '0;
		idle(4);
		#1;
		chk_word({18'h0_0000, avg_index_out}, 32'h0000_0001);
		chk_bit(sweep_start_out, 1'b0);
		arst_n_in <= 1'b1;
		s0 = starts;
		idle(100);
		chk_bit(starts - s0 >= 5, 1'b1);
		rd(`REG_CTRL);
		chk_word(rd_q, 32'h0000_0010);
		rd(8'h3C);
		chk_word(rd_q, 32'h0000_0000);
		wr(`REG_CMD, 32'h0000_0001);
		idle(30);
		s0 = starts;
		idle(50);
		chk_word(starts - s0, 32'h0000_0000);
		$display("free run and hold done");
		wr(`REG_CTRL, 32'h0000_0011);
		wr(`REG_CMD, 32'h0000_0002);
		idle(5);
		#1;
		chk_bit(waiting_out, 1'b1);
		ext_to(1'b1);
		wait_start(20);
		chk_bit(n < 20, 1'b1);
		chk_bit(sweeping_out, 1'b1);
		idle(20);
		rd(`REG_STATUS);
		chk_word(rd_q & 32'h0000_0083, 32'h0000_0000);
		ext_to(1'b0);
		wr(`REG_CTRL, 32'h0000_0009);
		wr(`REG_CMD, 32'h0000_0001);
		ext_to(1'b1);
		wait_start(20);
		chk_bit(n < 20, 1'b0);
		ext_to(1'b0);
		wait_start(20);
		chk_bit(n < 20, 1'b1);
		idle(20);
		$display("external trigger done");
		wr(`REG_DELAY, 32'h0000_0028);
		wr(`REG_CTRL, 32'h0000_0001);
		wr(`REG_CMD, 32'h0000_0002);
		ext_to(1'b1);
		wait_start(80);
		chk_bit(n >= 40 && n <= 48, 1'b1);
		idle(20);
		ext_to(1'b0);
		wr(`REG_DELAY, 32'h0000_0000);
		wr(`REG_CTRL, 32'h0000_0011);
		for (int i = 0; i < 2; i++) begin
			wr(`REG_HOLDOFF, (i == 0) ? 32'h0000_012C : 32'h0000_0000);
			idle(400);
			s0 = starts;
			repeat (2) begin
				ext_to(1'b1);
				idle(2);
				ext_to(1'b0);
				idle(60);
			end
			chk_word(starts - s0, i + 1);
		end
		wr(`REG_CTRL, 32'h0000_0000);
		idle(30);
		$display("delay and hold-off done");
		wr(`REG_CTRL, 32'h0000_0001);
		wr(`REG_AUTO, 32'h0000_000A);
		wr(`REG_CMD, 32'h0000_0002);
		wait_start(100);
		chk_bit(n >= 35 && n <= 50, 1'b1);
		idle(20);
		wr(`REG_AUTO, 32'h0000_0000);
		wr(`REG_CMD, 32'h0000_0002);
		wait_start(300);
		chk_bit(n < 300, 1'b0);
		wr(`REG_CTRL, 32'h0000_0021);
		wait_start(20);
		chk_bit(n < 20, 1'b1);
		chk_word({30'h0000_0000, meas_type_out}, 32'h0000_0001);
		idle(20);
		$display("auto trigger and spectrogram done");
		wr(`REG_LEVEL, 32'hFFFF_FC18);
		for (int i = 0; i < 2; i++) begin
			wr(`REG_CTRL, (i == 0) ? 32'h0000_0003 : 32'h0000_0004);
			wr(`REG_CMD, 32'h0000_0002);
			idle(5);
			if (i == 0) amp <= 16'hFE0C;
			else lvl <= 16'hFE0C;
			wait_start(20);
			chk_bit(n < 20, 1'b1);
			idle(20);
			amp <= 16'hF830;
			lvl <= 16'hF830;
		end
		wr(`REG_LEVEL, 32'hFFFF_8AD0);
		rd(`REG_LEVEL);
		chk_word({16'h0000, rd_q[15:0]}, 32'h0000_ADF8);
		wr(`REG_LEVEL, 32'h0000_1388);
		rd(`REG_LEVEL);
		chk_word({16'h0000, rd_q[15:0]}, 32'h0000_0BB8);
		reach <= 16'h03E8;
		idle(3);
		#1;
		chk_bit(hw_limited_out, 1'b1);
		rd(`REG_EXCESS);
		chk_word(rd_q, 32'h0000_07D0);
		reach <= 16'h7FFF;
		idle(3);
		#1;
		chk_bit(hw_limited_out, 1'b0);
		$display("level triggers done");
		wr(`REG_PERIOD, 32'h0000_0001);
		rd(`REG_PERIOD);
		chk_word(rd_q, 32'h0000_000D);
		wr(`REG_PERIOD, 32'h0000_0032);
		wr(`REG_CTRL, 32'h0000_0002);
		wr(`REG_CMD, 32'h0000_0002);
		wait_start(80);
		chk_bit(n <= 60, 1'b1);
		wr(`REG_OFFSET, 32'h0000_1388);
		rd(`REG_OFFSET);
		chk_word(rd_q, 32'h0000_03E8);
		wr(`REG_CMD, 32'h0000_0008);
		idle(2);
		rd(`REG_OFFSET);
		chk_word(rd_q, 32'h0000_0000);
		idle(20);
		$display("periodic done");
		wr(`REG_CTRL, 32'h0000_0080);
		wr(`REG_AVG, 32'h0000_0003);
		s0 = starts;
		c0 = clears;
		wr(`REG_CMD, 32'h0000_0004);
		idle(80);
		chk_word(starts - s0, 32'h0000_0003);
		chk_word(clears - c0, 32'h0000_0001);
		chk_word({18'h0_0000, avg_index_out}, 32'h0000_0003);
		rd(`REG_STATUS);
		chk_word(rd_q & 32'h0000_0003, 32'h0000_0000);
		$display("restart done");
		test_done();
	end
endmodule // sweep_trigger_sequencer_test
